// ### logic/pmc_defines.vh
// Constants and behaviour summary for the operating mode controller.
// How it works
// - Active mode enables instruction fetch and execution.
// - Halt instruction moves active into standby.
// - Armed sleep write moves active into sleep.
// - Port A reset combination forces reset state.
// - Standby keeps peripheral clock enables running.
// - Standby gates only the instruction clock.
// - Standby freezes registers, RAM and pins not carrying an alternate function.
// - Any reset or enabled interrupt ends standby.
// - Port B pin 0 may carry 2 kHz tap.
// - Port B pin 1 may carry 32 kHz tap.
// - Port B pin 2 may carry 1 kHz tap.
// - Port B pins: in/out, push-pull/open-drain, pin3 PWM.
// - Strobe shows reset state, pulses on port B writes.
// - Port A feeds test variables and event counters.
// - Sleep stops oscillator; only reset input lives.
// - Wake-up clears sleep bit, keeps arm latch.
// - Standby lets level measurement finish first.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMC_CLK_HZ          10000000
`define PMC_SYS_HZ          32768
// Core cycles per half period of the 32 kHz tap: CLK_HZ / (2 * SYS_HZ),
// rounded down.
`define PMC_SYS_DIV         8'h98
`define PMC_DIV_W           8
// Prescaler taps: bit index of a counter advanced on every second tick, once per 32 kHz period.
`define PMC_TAP_2KHZ_BIT    3
`define PMC_TAP_1KHZ_BIT    4
`define PMC_PRE_W           5

// ----------------------------------------------------------------------
// Port B output source selects
// ----------------------------------------------------------------------
`define PMC_PBSEL_DATA      2'h0
`define PMC_PBSEL_ALT       2'h1

`endif

// ### logic/pmc_sync.v
// Two-flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // pmc_sync
`default_nettype wire

// ### logic/pmc_pin_drv.v
// One port B pin driver: source select, direction and driver style.
`timescale 1ns/1ps
`default_nettype none
module pmc_pin_drv (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Control
    input  wire hold,
    input  wire hiz,
    input  wire alt_sel,
    input  wire alt_val,
    input  wire data_val,
    input  wire is_out,
    input  wire open_drain,
    // Pin
    output reg  pin_o,
    output reg  pin_oe
);
    reg val;

    always @* begin
        val = alt_sel ? alt_val : data_val;
    end

    always @(posedge clk) begin
        if (rst) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else if (hiz) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else if (!hold) begin
            // An open-drain driver only ever pulls low.
            pin_o  <= open_drain ? 1'b0 : val;
            pin_oe <= is_out & (open_drain ? ~val : 1'b1);
        end
    end
endmodule // pmc_pin_drv
`default_nettype wire

// ### logic/pmc_mode_ctrl.v
// Operating mode controller: active, standby, sleep and reset state.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.vh"
module pmc_mode_ctrl (
    // Clock and reset
    input  wire       CORE_CLK,
    input  wire       RST,
    // Reset sources
    input  wire       POR,
    input  wire       RESET_PIN,
    input  wire       PORTA_RESET_REQ,
    input  wire       SYS_RESET_REQ,
    // Core requests
    input  wire       HALT_EXEC,
    input  wire       SLEEP_WRITE,
    input  wire       SLEEP_ARM_WRITE,
    input  wire       SLEEP_ARM_VALUE,
    input  wire       IRQ_PENDING,
    input  wire       LEVEL_MEAS_BUSY,
    // Port B control
    input  wire [3:0] PORT_B_DATA,
    input  wire [3:0] PORT_B_DIR_OUT,
    input  wire [3:0] PORT_B_OPEN_DRAIN,
    input  wire [3:0] PORT_B_ALT_SEL,
    input  wire       PWM_IN,
    input  wire       PORT_B_WRITE,
    // Port A pins
    input  wire [3:0] PORT_A_IN,
    // Mode outputs
    output reg        EXEC_CLK_EN,
    output reg        PERIPH_CLK_EN,
    output reg        OSC_EN,
    output reg        STATE_HOLD,
    output reg        LEVEL_DET_EN,
    output reg        CPU_RESET,
    output reg        SLEEP_FLAG,
    output reg        SLEEP_ARM_LATCH,
    output reg        STANDBY,
    // Pins
    output reg        STROBE,
    output wire [3:0] PORT_B_O,
    output wire [3:0] PORT_B_OE,
    // Port A functions
    output reg        BRANCH_TEST_VARIABLE1,
    output reg        BRANCH_TEST_VARIABLE2,
    output reg        EVENT_COUNT_IN0,
    output reg        EVENT_COUNT_IN3
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [3:0] ST_RESET   = 4'h1;
    localparam [3:0] ST_ACTIVE  = 4'h2;
    localparam [3:0] ST_STANDBY = 4'h4;
    localparam [3:0] ST_SLEEP   = 4'h8;

    // The divider wraps once per half period of the 32 kHz tap. The count is
    // rounded down, so the taps run slightly fast; timing that relies on an
    // exact 32768 Hz must allow for that.
    localparam [`PMC_DIV_W-1:0] DIV_LAST = `PMC_SYS_DIV - 8'h01;

    reg [3:0]            state_reg;
    reg [3:0]            state_next;
    reg [`PMC_DIV_W-1:0] div_reg;
    reg                  clk32_reg;
    reg [`PMC_PRE_W-1:0] pre_reg;
    reg                  arm_reg;
    reg                  meas_done_reg;

    wire [3:0] pa_s;
    wire [1:0] rst_s;
    wire       tick;
    wire       any_reset;
    wire       sleeping;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // The reset pin and the port A combination come from outside the clock
    // domain, so they pass two flip-flops first. Power-on reset and the
    // system reset request are made on this clock and are used directly.
    pmc_sync #(.W(4)) u_sync_pa (
        .clk (CORE_CLK),
        .rst (RST),
        .d   (PORT_A_IN),
        .q   (pa_s)
    );

    pmc_sync #(.W(2)) u_sync_rst (
        .clk (CORE_CLK),
        .rst (RST),
        .d   ({RESET_PIN, PORTA_RESET_REQ}),
        .q   (rst_s)
    );

    assign any_reset = POR | rst_s[1] | rst_s[0] | SYS_RESET_REQ;
    assign sleeping  = (state_reg == ST_SLEEP);

    // ------------------------------------------------------------------
    // System clock divider and prescaler taps
    // ------------------------------------------------------------------
    // Divider, tap and prescaler all stop while asleep, so a wake-up starts
    // the taps from a known phase.
    assign tick = (div_reg == DIV_LAST);

    always @(posedge CORE_CLK) begin
        if (RST || sleeping) begin
            // The oscillator is stopped while asleep.
            div_reg   <= {`PMC_DIV_W{1'b0}};
            clk32_reg <= 1'b0;
            pre_reg   <= {`PMC_PRE_W{1'b0}};
        end else if (tick) begin
            div_reg   <= {`PMC_DIV_W{1'b0}};
            clk32_reg <= ~clk32_reg;
            if (clk32_reg) begin
                pre_reg <= pre_reg + 1'b1;
            end
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------
    // Priority in active mode is reset, then an armed sleep write, then halt.
    // Requests outside their mode are ignored; there is no error indication.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (!any_reset) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (any_reset) begin
                    state_next = ST_RESET;
                end else if (SLEEP_WRITE && arm_reg) begin
                    state_next = ST_SLEEP;
                end else if (HALT_EXEC) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (any_reset) begin
                    state_next = ST_RESET;
                end else if (IRQ_PENDING) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_SLEEP: begin
                // Only a reset source can wake the device.
                if (any_reset) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Sleep arm latch and sleep flag
    // ------------------------------------------------------------------
    // The arm latch is cleared only by power-on reset (POR or RST) or a write
    // of 0, so software can tell a wake-up from a power-up.
    always @(posedge CORE_CLK) begin
        if (RST || POR) begin
            arm_reg <= 1'b0;
        end else if (SLEEP_ARM_WRITE) begin
            arm_reg <= SLEEP_ARM_VALUE;
        end
    end

    // The flag clears on the edge that leaves sleep, whichever reset woke it.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            SLEEP_FLAG      <= 1'b0;
            SLEEP_ARM_LATCH <= 1'b0;
        end else begin
            SLEEP_ARM_LATCH <= arm_reg;
            if (state_next == ST_SLEEP) begin
                SLEEP_FLAG <= 1'b1;
            end else if (sleeping && state_next != ST_SLEEP) begin
                SLEEP_FLAG <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Level detector: a measurement under way completes in standby
    // ------------------------------------------------------------------
    // The done flag keeps the detector off once the running measurement ends,
    // even if a new one is requested while the core is halted.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            meas_done_reg <= 1'b0;
        end else if (state_next != ST_STANDBY) begin
            meas_done_reg <= 1'b0;
        end else if (!LEVEL_MEAS_BUSY) begin
            meas_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------------
    // Mode outputs are registered from the next state, so they change at the
    // same edge as the state and never glitch.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            EXEC_CLK_EN   <= 1'b0;
            PERIPH_CLK_EN <= 1'b0;
            OSC_EN        <= 1'b1;
            STATE_HOLD    <= 1'b0;
            LEVEL_DET_EN  <= 1'b0;
            CPU_RESET     <= 1'b1;
            STANDBY       <= 1'b0;
        end else begin
            EXEC_CLK_EN   <= (state_next == ST_ACTIVE);
            PERIPH_CLK_EN <= (state_next == ST_ACTIVE) ||
                             (state_next == ST_STANDBY);
            OSC_EN        <= (state_next != ST_SLEEP);
            STATE_HOLD    <= (state_next == ST_STANDBY);
            LEVEL_DET_EN  <= (state_next == ST_ACTIVE) ||
                             ((state_next == ST_STANDBY) &&
                              LEVEL_MEAS_BUSY && !meas_done_reg);
            CPU_RESET     <= (state_next == ST_RESET) ||
                             (state_next == ST_SLEEP);
            STANDBY       <= (state_next == ST_STANDBY);
        end
    end

    // ------------------------------------------------------------------
    // Strobe and port A functions
    // ------------------------------------------------------------------
    // The strobe stays high for the whole reset or sleep state and adds one
    // cycle for every port B write.
    // Port A functions come through the synchroniser, so they lag the pins
    // by three cycles in all.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            STROBE                <= 1'b1;
            BRANCH_TEST_VARIABLE1 <= 1'b0;
            BRANCH_TEST_VARIABLE2 <= 1'b0;
            EVENT_COUNT_IN0       <= 1'b0;
            EVENT_COUNT_IN3       <= 1'b0;
        end else begin
            STROBE <= (state_next == ST_RESET) || (state_next == ST_SLEEP) ||
                      PORT_B_WRITE;
            // Port A inputs are dead while asleep.
            BRANCH_TEST_VARIABLE1 <= pa_s[0] & ~sleeping;
            BRANCH_TEST_VARIABLE2 <= pa_s[1] & ~sleeping;
            EVENT_COUNT_IN0       <= pa_s[0] & ~sleeping;
            EVENT_COUNT_IN3       <= pa_s[3] & ~sleeping;
        end
    end

    // ------------------------------------------------------------------
    // Port B drivers
    // ------------------------------------------------------------------
    // In standby a pin keeps its last value unless it carries an alternate
    // function: the taps and the PWM keep running like the other peripherals.
    // In sleep every pin is released.
    wire [3:0] alt_val;

    assign alt_val = {PWM_IN,
                      pre_reg[`PMC_TAP_1KHZ_BIT],
                      clk32_reg,
                      pre_reg[`PMC_TAP_2KHZ_BIT]};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pb
            pmc_pin_drv u_drv (
                .clk        (CORE_CLK),
                .rst        (RST),
                .hold       (STATE_HOLD & ~PORT_B_ALT_SEL[gi]),
                .hiz        (sleeping),
                .alt_sel    (PORT_B_ALT_SEL[gi]),
                .alt_val    (alt_val[gi]),
                .data_val   (PORT_B_DATA[gi]),
                .is_out     (PORT_B_DIR_OUT[gi]),
                .open_drain (PORT_B_OPEN_DRAIN[gi]),
                .pin_o      (PORT_B_O[gi]),
                .pin_oe     (PORT_B_OE[gi])
            );
        end
    endgenerate
endmodule // pmc_mode_ctrl
`default_nettype wire

// ### tb/pmc_mode_ctrl_assertions.sv
// Port-level checks for the operating mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_assertions (
    // Clock and reset
    input wire logic       CORE_CLK,
    input wire logic       RST,
    // Inputs
    input wire logic       POR,
    input wire logic       RESET_PIN,
    input wire logic       PORTA_RESET_REQ,
    input wire logic       SYS_RESET_REQ,
    input wire logic       HALT_EXEC,
    input wire logic       SLEEP_WRITE,
    input wire logic       IRQ_PENDING,
    input wire logic [3:0] PORT_B_ALT_SEL,
    input wire logic [3:0] PORT_B_DIR_OUT,
    input wire logic [3:0] PORT_B_OPEN_DRAIN,
    input wire logic       PWM_IN,
    input wire logic       PORT_B_WRITE,
    // Outputs
    input wire logic       EXEC_CLK_EN,
    input wire logic       PERIPH_CLK_EN,
    input wire logic       OSC_EN,
    input wire logic       STATE_HOLD,
    input wire logic       CPU_RESET,
    input wire logic       SLEEP_FLAG,
    input wire logic       SLEEP_ARM_LATCH,
    input wire logic       STANDBY,
    input wire logic       STROBE,
    input wire logic [3:0] PORT_B_O,
    input wire logic [3:0] PORT_B_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Synchronised pins lag by two cycles, so a quiet history is kept.
    logic [2:0] pin_h_reg;
    logic       quiet;
    logic       act;
    always_ff @(posedge CORE_CLK) begin
        pin_h_reg <= {pin_h_reg[1:0], RESET_PIN | PORTA_RESET_REQ};
    end
    assign quiet = ~|pin_h_reg & ~RESET_PIN & ~PORTA_RESET_REQ & ~POR & ~SYS_RESET_REQ;
    assign act = EXEC_CLK_EN & ~CPU_RESET & quiet;
    sequence halt_seq;
        act && HALT_EXEC && !SLEEP_WRITE;
    endsequence
    sequence pin_held;
        RESET_PIN[*3];
    endsequence
    halt_standby_a: assert property (halt_seq |=> STANDBY && !EXEC_CLK_EN)
        else $error("halt did not enter standby");
    standby_keep_a: assert property (
        STANDBY |-> STATE_HOLD && PERIPH_CLK_EN && OSC_EN && !EXEC_CLK_EN)
        else $error("standby state wrong");
    irq_wake_a: assert property (
        STANDBY && IRQ_PENDING && quiet |=> EXEC_CLK_EN && !STANDBY)
        else $error("interrupt did not end standby");
    sleep_enter_a: assert property (
        act && SLEEP_WRITE && SLEEP_ARM_LATCH |=> SLEEP_FLAG && !OSC_EN)
        else $error("armed sleep write not taken");
    sleep_refuse_a: assert property (
        act && SLEEP_WRITE && !SLEEP_ARM_LATCH |=> !SLEEP_FLAG)
        else $error("unarmed sleep write taken");
    wake_keep_a: assert property (
        (SLEEP_FLAG && !POR) ##0 pin_held
        |-> ##[1:2] (!SLEEP_FLAG && CPU_RESET && SLEEP_ARM_LATCH))
        else $error("wake-up did not keep arm latch");
    release_run_a: assert property (
        $fell(RST) && quiet |=> EXEC_CLK_EN && !CPU_RESET)
        else $error("not active after reset");
    reset_strobe_a: assert property (CPU_RESET |-> STROBE)
        else $error("strobe low in reset state");
    write_strobe_a: assert property (act && PORT_B_WRITE |=> STROBE)
        else $error("strobe missed port write");
    pwm_pin_a: assert property (
        act && !SLEEP_WRITE && PORT_B_ALT_SEL[3] && PORT_B_DIR_OUT[3] && !PORT_B_OPEN_DRAIN[3]
        |=> PORT_B_OE[3] && PORT_B_O[3] == $past(PWM_IN))
        else $error("pin 3 not carrying pwm");
endmodule // pmc_mode_ctrl_assertions
`default_nettype wire

// ### tb/pmc_core_model.sv
// Processor core model issuing halt, sleep, interrupt and port writes.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    // Clock
    input wire logic CORE_CLK,
    // Requests
    output logic     HALT_EXEC,
    output logic     SLEEP_WRITE,
    output logic     SLEEP_ARM_WRITE,
    output logic     SLEEP_ARM_VALUE,
    output logic     IRQ_PENDING,
    output logic     PORT_B_WRITE
);
    initial begin
        {HALT_EXEC, SLEEP_WRITE, SLEEP_ARM_WRITE, SLEEP_ARM_VALUE} = 4'h0;
        {IRQ_PENDING, PORT_B_WRITE} = 2'h0;
    end
    task automatic halt();
        @(negedge CORE_CLK) HALT_EXEC = 1'b1;
        @(negedge CORE_CLK) HALT_EXEC = 1'b0;
    endtask
    task automatic arm(input logic v);
        @(negedge CORE_CLK) {SLEEP_ARM_WRITE, SLEEP_ARM_VALUE} = {1'b1, v};
        @(negedge CORE_CLK) SLEEP_ARM_WRITE = 1'b0;
    endtask
    // Callers arm first; an unarmed write is only sent to see it refused.
    task automatic sleep();
        @(negedge CORE_CLK) SLEEP_WRITE = 1'b1;
        @(negedge CORE_CLK) SLEEP_WRITE = 1'b0;
    endtask
    task automatic wr();
        @(negedge CORE_CLK) PORT_B_WRITE = 1'b1;
        @(negedge CORE_CLK) PORT_B_WRITE = 1'b0;
    endtask
    // A slow answer waits n cycles before raising the request.
    task automatic irq(input int n);
        repeat (n) @(negedge CORE_CLK);
        @(negedge CORE_CLK) IRQ_PENDING = 1'b1;
        @(negedge CORE_CLK) IRQ_PENDING = 1'b0;
    endtask
endmodule // pmc_core_model
`default_nettype wire

// ### tb/pmc_mode_ctrl_tb_top.sv
// Self-checking testbench for the operating mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_tb_top;
    logic       CORE_CLK, RST, POR, RESET_PIN, PORTA_RESET_REQ, SYS_RESET_REQ;
    logic       LEVEL_MEAS_BUSY, PWM_IN, HALT_EXEC, SLEEP_WRITE, SLEEP_ARM_WRITE;
    logic       SLEEP_ARM_VALUE, IRQ_PENDING, PORT_B_WRITE;
    logic [3:0] PORT_B_DATA, PORT_B_DIR_OUT, PORT_B_OPEN_DRAIN, PORT_B_ALT_SEL;
    logic [3:0] PORT_A_IN, PORT_B_O, PORT_B_OE;
    logic       EXEC_CLK_EN, PERIPH_CLK_EN, OSC_EN, STATE_HOLD, LEVEL_DET_EN, CPU_RESET;
    logic       SLEEP_FLAG, SLEEP_ARM_LATCH, STANDBY, STROBE;
    logic       BRANCH_TEST_VARIABLE1, BRANCH_TEST_VARIABLE2, EVENT_COUNT_IN0, EVENT_COUNT_IN3;
    int         num_errors, tests_run, c0, c1, c2;
    logic [3:0] a, e, prev;
    pmc_mode_ctrl dut_u (.*);
    pmc_core_model core_u (.*);
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [3:0] exp_oe(input logic [3:0] dir, od, d);
        return dir & ~(od & d);
    endfunction
    initial begin
        repeat (100000) @(posedge CORE_CLK);
        num_errors++;
        test_done();
    end
    initial begin
        {RST, POR, RESET_PIN, PORTA_RESET_REQ, SYS_RESET_REQ} = 5'h10;
        {LEVEL_MEAS_BUSY, PWM_IN, PORT_A_IN} = 6'h00;
        {PORT_B_DATA, PORT_B_DIR_OUT, PORT_B_OPEN_DRAIN, PORT_B_ALT_SEL} = 16'h0000;
        void'($urandom(1));
        cyc(4);
        RST = 1'b0;
        cyc(3);
        chk({EXEC_CLK_EN, CPU_RESET, STROBE}, 3'h4);
        $display("test reset_release done");
        for (int i = 0; i < 8; i++) begin
            LEVEL_MEAS_BUSY = 1'($urandom);
            core_u.halt();
            chk({STANDBY, EXEC_CLK_EN, PERIPH_CLK_EN}, 3'h5);
            chk({STATE_HOLD, OSC_EN}, 2'h3);
            chk(LEVEL_DET_EN, LEVEL_MEAS_BUSY);
            LEVEL_MEAS_BUSY = 1'b0;
            cyc(2);
            chk(LEVEL_DET_EN, 1'b0);
            core_u.irq($urandom_range(0, 7));
            chk({STANDBY, EXEC_CLK_EN}, 2'h1);
        end
        $display("test halt_wake done");
        for (int i = 0; i < 8; i++) begin
            {PORT_B_DATA, PORT_B_DIR_OUT, PORT_B_OPEN_DRAIN} = 12'($urandom);
            cyc(2);
            e = exp_oe(PORT_B_DIR_OUT, PORT_B_OPEN_DRAIN, PORT_B_DATA);
            chk({PORT_B_OE, PORT_B_O & PORT_B_OE}, {e, PORT_B_DATA & e});
            core_u.wr();
            chk(STROBE, 1'b1);
            cyc(1);
            chk(STROBE, 1'b0);
        end
        a = PORT_B_DATA;
        core_u.halt();
        PORT_B_DATA = ~a;
        cyc(2);
        chk({PORT_B_OE, PORT_B_O & PORT_B_OE}, {e, a & e});
        core_u.irq(0);
        {PORT_B_DIR_OUT, PORT_B_OPEN_DRAIN, PORT_B_ALT_SEL} = 12'hf0f;
        for (int i = 0; i < 16; i++) begin
            PWM_IN = 1'($urandom);
            cyc(2);
            chk(PORT_B_O[3], PWM_IN);
        end
        PORT_B_ALT_SEL = 4'h7;
        cyc(2);
        {c0, c1, c2} = '0;
        prev = PORT_B_O;
        repeat (20000) begin
            cyc(1);
            c0 += int'(PORT_B_O[0] != prev[0]);
            c1 += int'(PORT_B_O[1] != prev[1]);
            c2 += int'(PORT_B_O[2] != prev[2]);
            prev = PORT_B_O;
        end
        chk(c1 > c0 && c0 > c2 && c2 > 0, 1'b1);
        $display("test port_b done");
        for (int i = 0; i < 6; i++) begin
            a = 4'($urandom);
            PORT_A_IN = a;
            cyc(4);
            chk({BRANCH_TEST_VARIABLE1, EVENT_COUNT_IN0, BRANCH_TEST_VARIABLE2, EVENT_COUNT_IN3},
                {a[0], a[0], a[1], a[3]});
        end
        $display("test port_a done");
        PORT_A_IN = 4'hf;
        core_u.sleep();
        chk(SLEEP_FLAG, 1'b0);
        core_u.arm(1'b1);
        core_u.sleep();
        chk({SLEEP_FLAG, OSC_EN, CPU_RESET, STROBE}, 4'hb);
        cyc(1);
        chk(PORT_B_OE, 4'h0);
        chk({BRANCH_TEST_VARIABLE1, BRANCH_TEST_VARIABLE2}, 2'h0);
        chk({EVENT_COUNT_IN0, EVENT_COUNT_IN3}, 2'h0);
        RESET_PIN = 1'b1;
        cyc(5);
        chk({SLEEP_FLAG, SLEEP_ARM_LATCH, CPU_RESET, OSC_EN}, 4'h7);
        RESET_PIN = 1'b0;
        cyc(5);
        chk({EXEC_CLK_EN, CPU_RESET}, 2'h2);
        core_u.arm(1'b0);
        core_u.sleep();
        chk({SLEEP_FLAG, SLEEP_ARM_LATCH}, 2'h0);
        core_u.arm(1'b1);
        $display("test sleep done");
        PORTA_RESET_REQ = 1'b1;
        cyc(5);
        chk({CPU_RESET, EXEC_CLK_EN, STROBE}, 3'h5);
        PORTA_RESET_REQ = 1'b0;
        cyc(5);
        core_u.halt();
        SYS_RESET_REQ = 1'b1;
        cyc(2);
        chk({STANDBY, CPU_RESET, SLEEP_ARM_LATCH}, 3'h3);
        SYS_RESET_REQ = 1'b0;
        POR = 1'b1;
        cyc(1);
        POR = 1'b0;
        cyc(3);
        chk({SLEEP_ARM_LATCH, EXEC_CLK_EN}, 2'h1);
        $display("test resets done");
        test_done();
    end
endmodule // pmc_mode_ctrl_tb_top
bind pmc_mode_ctrl pmc_mode_ctrl_assertions chk_u (.*);
`default_nettype wire
